// File: logic/idu_pkg.sv
// integer divide unit: shared encodings, field positions and timing counts
// assumes a 32-bit core whose decode stage hands over the instruction word and both operand values
`default_nettype none

package idu_pkg;
    localparam int unsigned IDU_XLEN      = 32;
    localparam int unsigned IDU_CNT_W     = 5;
    // one quotient bit per step, then one cycle to present the answer
    localparam logic [4:0]  IDU_LAST_STEP = 5'h1F;
    localparam int unsigned IDU_LATENCY   = 34;

    // instruction field positions
    localparam int unsigned IDU_OPC_MSB   = 31;
    localparam int unsigned IDU_OPC_LSB   = 26;
    localparam int unsigned IDU_DEST_MSB  = 15;
    localparam int unsigned IDU_DEST_LSB  = 11;
    localparam int unsigned IDU_SEL_MSB   = 10;
    localparam int unsigned IDU_SEL_LSB   = 6;
    localparam int unsigned IDU_FN_MSB    = 5;
    localparam int unsigned IDU_FN_LSB    = 0;

    // encodings
    localparam logic [5:0]  IDU_OPC_SPECIAL          = 6'h00;
    localparam logic [5:0]  IDU_SIGNED_DIVIDE_FUNCTION   = 6'h1A;
    localparam logic [5:0]  IDU_UNSIGNED_DIVIDE_FUNCTION = 6'h1B;
    localparam logic [4:0]  IDU_SEL_QUOTIENT         = 5'h02;
    localparam logic [4:0]  IDU_SEL_REMAINDER        = 5'h03;
    localparam logic [9:0]  IDU_LEGACY_ZERO          = 10'h000;

    localparam logic [31:0] IDU_SREG_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        IDU_ST_IDLE = 2'b00,
        IDU_ST_RUN  = 2'b01,
        IDU_ST_FIN  = 2'b11
    } idu_state_t;
endpackage : idu_pkg

`default_nettype wire

// File: logic/idu_div_if.sv
// integer divide unit: carrier between the control top and the iterative divider
// assumes one clock domain; the control side drives start and operands
`default_nettype none

interface idu_div_if;
    logic        start;
    logic        is_signed;
    logic [31:0] dividend;
    logic [31:0] divisor;
    logic        ready;
    logic        done;
    logic [31:0] quotient;
    logic [31:0] remainder;

    modport ctrl (output start, is_signed, dividend, divisor, input ready, done, quotient, remainder);
    modport core (input start, is_signed, dividend, divisor, output ready, done, quotient, remainder);
endinterface : idu_div_if

`default_nettype wire

// File: logic/idu_divcore.sv
// integer divide unit: restoring divider, one quotient bit per clock
// assumes start is only raised while ready is high
`default_nettype none

module idu_divcore (
    input  wire logic ref_clk,
    input  wire logic rst,
    idu_div_if.core   dv
);
    idu_pkg::idu_state_t state;
    logic [4:0]          step;
    logic [31:0]         quo;
    logic [31:0]         rem;
    logic [31:0]         dmag;
    logic                q_neg;
    logic                r_neg;
    logic [32:0]         trial;

    // ---------------------------------------------------------------
    // sequencing
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= idu_pkg::IDU_ST_IDLE;
            step  <= 5'h00;
        end else begin
            unique case (state)
                idu_pkg::IDU_ST_IDLE: begin
                    step <= 5'h00;
                    if (dv.start) begin
                        state <= idu_pkg::IDU_ST_RUN;
                    end
                end
                idu_pkg::IDU_ST_RUN: begin
                    step <= step + 5'h01;
                    // fixed step count: zero divisor and overflow cases take the same time
                    if (step == idu_pkg::IDU_LAST_STEP) begin
                        state <= idu_pkg::IDU_ST_FIN;
                    end
                end
                idu_pkg::IDU_ST_FIN: begin
                    state <= idu_pkg::IDU_ST_IDLE;
                end
                default: begin
                    state <= idu_pkg::IDU_ST_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // datapath on magnitudes, sign applied at the end
    // ---------------------------------------------------------------
    assign trial = {rem, quo[31]} - {1'b0, dmag};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            quo   <= 32'h0000_0000;
            rem   <= 32'h0000_0000;
            dmag  <= 32'h0000_0000;
            q_neg <= 1'b0;
            r_neg <= 1'b0;
        end else if (state == idu_pkg::IDU_ST_IDLE && dv.start) begin
            quo   <= (dv.is_signed && dv.dividend[31]) ? 32'h0 - dv.dividend : dv.dividend;
            dmag  <= (dv.is_signed && dv.divisor[31]) ? 32'h0 - dv.divisor : dv.divisor;
            rem   <= 32'h0000_0000;
            q_neg <= dv.is_signed && (dv.dividend[31] ^ dv.divisor[31]);
            r_neg <= dv.is_signed && dv.dividend[31];
        end else if (state == idu_pkg::IDU_ST_RUN) begin
            if (!trial[32]) begin
                rem <= trial[31:0];
                quo <= {quo[30:0], 1'b1};
            end else begin
                rem <= {rem[30:0], quo[31]};
                quo <= {quo[30:0], 1'b0};
            end
        end else if (state == idu_pkg::IDU_ST_FIN) begin
            quo <= q_neg ? 32'h0 - quo : quo;
            rem <= r_neg ? 32'h0 - rem : rem;
        end
    end

    assign dv.ready     = (state == idu_pkg::IDU_ST_IDLE);
    assign dv.done      = (state == idu_pkg::IDU_ST_FIN);
    assign dv.quotient  = q_neg ? 32'h0 - quo : quo;
    assign dv.remainder = r_neg ? 32'h0 - rem : rem;
endmodule : idu_divcore

`default_nettype wire

// File: logic/idu_sreg.sv
// integer divide unit: quotient and remainder special registers with read interlock
// assumes pend_set and wr_en never coincide
`default_nettype none

module idu_sreg (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        pend_set,
    input  wire logic        wr_en,
    input  wire logic [31:0] wr_quo,
    input  wire logic [31:0] wr_rem,
    input  wire logic        rd_req,
    input  wire logic        rd_sel,
    output logic             rd_ack,
    output logic             rd_valid,
    output logic [31:0]      rd_data,
    output logic             pending
);
    logic [31:0] quotient_special_reg;
    logic [31:0] remainder_special_reg;

    // a read waits for the divide in flight rather than seeing stale values
    assign rd_ack = rd_req && !pending;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pending <= 1'b0;
        end else if (pend_set) begin
            pending <= 1'b1;
        end else if (wr_en) begin
            pending <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            quotient_special_reg  <= idu_pkg::IDU_SREG_RESET;
            remainder_special_reg <= idu_pkg::IDU_SREG_RESET;
        end else if (wr_en) begin
            quotient_special_reg  <= wr_quo;
            remainder_special_reg <= wr_rem;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_valid <= 1'b0;
            rd_data  <= 32'h0000_0000;
        end else begin
            rd_valid <= rd_ack;
            if (rd_ack) begin
                rd_data <= rd_sel ? remainder_special_reg : quotient_special_reg;
            end
        end
    end
endmodule : idu_sreg

`default_nettype wire

// File: logic/idu_top.sv
// integer divide unit: decode, issue, special-register and writeback control
// assumes the register file supplies both operand values with the instruction word
//
// What this block does
// - legacy word divide divides two 32-bit operands as signed values
// - legacy divide puts quotient and remainder into their special registers
// - legacy divide never raises an arithmetic exception
// - zero divisor on legacy divide leaves arbitrary values but still completes
// - special register reads stall until a pending divide has written them
// - divider runs beside other instructions without changing visible results
// - newer family writes only quotient or remainder into the result register
// - newer family: primary opcode 000000, function 011010 signed, 011011 unsigned
// - instruction bits 10..6: 00010 gives quotient, 00011 gives remainder
// - results follow truncated division; remainder takes dividend sign, smaller magnitude
// - signed variants use signed operands, unsigned variants unsigned, 32-bit results
// - newer family never traps on zero divisor; result unspecified
// - in newer-release mode legacy divide encodings raise reserved instruction
`default_nettype none

module idu_top (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        release6_mode,
    input  wire logic        issue_valid,
    output logic             issue_ready,
    input  wire logic [31:0] issue_instr,
    input  wire logic [31:0] num_val,
    input  wire logic [31:0] den_val,
    input  wire logic        mf_req,
    input  wire logic        mf_sel,
    output logic             mf_ack,
    output logic             mf_valid,
    output logic [31:0]      mf_data,
    output logic             rsvd_instr_exc,
    output logic             wb_valid,
    output logic             wb_gpr,
    output logic [4:0]       wb_dest,
    output logic [31:0]      wb_data
);
    idu_div_if dv ();

    logic [5:0] opc;
    logic [5:0] fn;
    logic [4:0] sel;
    logic [9:0] low_zero;
    logic       fn_signed;
    logic       fn_div;
    logic       is_legacy;
    logic       is_newer;
    logic       taken;
    logic       run_div;
    logic       op_legacy;
    logic       op_rem;
    logic [4:0] op_dest;
    logic       sreg_pending;
    logic       sreg_we;

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    assign opc       = issue_instr[idu_pkg::IDU_OPC_MSB:idu_pkg::IDU_OPC_LSB];
    assign fn        = issue_instr[idu_pkg::IDU_FN_MSB:idu_pkg::IDU_FN_LSB];
    assign sel       = issue_instr[idu_pkg::IDU_SEL_MSB:idu_pkg::IDU_SEL_LSB];
    assign low_zero  = issue_instr[idu_pkg::IDU_DEST_MSB:idu_pkg::IDU_SEL_LSB];
    assign fn_signed = (fn == idu_pkg::IDU_SIGNED_DIVIDE_FUNCTION);
    assign fn_div    = fn_signed || (fn == idu_pkg::IDU_UNSIGNED_DIVIDE_FUNCTION);
    assign is_legacy = (opc == idu_pkg::IDU_OPC_SPECIAL) && fn_div
                       && (low_zero == idu_pkg::IDU_LEGACY_ZERO);
    assign is_newer  = (opc == idu_pkg::IDU_OPC_SPECIAL) && fn_div
                       && (sel == idu_pkg::IDU_SEL_QUOTIENT || sel == idu_pkg::IDU_SEL_REMAINDER);

    // one divide in flight; other instructions keep flowing around the unit
    assign issue_ready = dv.ready;
    assign taken       = issue_valid && issue_ready;
    // legacy encodings only execute when the core is not in newer-release mode
    assign run_div     = taken && (is_newer || (is_legacy && !release6_mode));

    // ---------------------------------------------------------------
    // divider launch
    // ---------------------------------------------------------------
    assign dv.start     = run_div;
    assign dv.is_signed = fn_signed;
    assign dv.dividend  = num_val;
    assign dv.divisor   = den_val;

    idu_divcore u_core (
        .ref_clk (ref_clk),
        .rst     (rst),
        .dv      (dv)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            op_legacy <= 1'b0;
            op_rem    <= 1'b0;
            op_dest   <= 5'h00;
        end else if (run_div) begin
            op_legacy <= is_legacy;
            op_rem    <= (sel == idu_pkg::IDU_SEL_REMAINDER);
            op_dest   <= issue_instr[idu_pkg::IDU_DEST_MSB:idu_pkg::IDU_DEST_LSB];
        end
    end

    // ---------------------------------------------------------------
    // exception report: only the reserved-encoding case, never arithmetic
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rsvd_instr_exc <= 1'b0;
        end else begin
            rsvd_instr_exc <= taken && is_legacy && release6_mode;
        end
    end

    // ---------------------------------------------------------------
    // special registers, written only by the legacy divide
    // ---------------------------------------------------------------
    assign sreg_we = dv.done && op_legacy;

    idu_sreg u_sreg (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .pend_set (run_div && is_legacy),
        .wr_en    (sreg_we),
        .wr_quo   (dv.quotient),
        .wr_rem   (dv.remainder),
        .rd_req   (mf_req),
        .rd_sel   (mf_sel),
        .rd_ack   (mf_ack),
        .rd_valid (mf_valid),
        .rd_data  (mf_data),
        .pending  (sreg_pending)
    );

    // ---------------------------------------------------------------
    // completion and general-register writeback
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wb_valid <= 1'b0;
            wb_gpr   <= 1'b0;
            wb_dest  <= 5'h00;
            wb_data  <= 32'h0000_0000;
        end else begin
            wb_valid <= dv.done;
            wb_gpr   <= dv.done && !op_legacy;
            if (dv.done) begin
                wb_dest <= op_dest;
                // a legacy divide reports the quotient here too, but wb_gpr stays low
                wb_data <= op_rem ? dv.remainder : dv.quotient;
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    logic [31:0] chk_a;
    logic [31:0] chk_b;
    logic        chk_sgn;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            chk_a   <= 32'h0000_0000;
            chk_b   <= 32'h0000_0000;
            chk_sgn <= 1'b0;
        end else if (run_div) begin
            chk_a   <= num_val;
            chk_b   <= den_val;
            chk_sgn <= fn_signed;
        end
    end

    chk_rsvd_legacy: assert property (@(posedge ref_clk) disable iff (rst)
        taken && is_legacy && release6_mode |=> rsvd_instr_exc && !wb_valid && issue_ready)
        else $error("legacy divide in newer-release mode did not raise reserved instruction");

    chk_no_trap: assert property (@(posedge ref_clk) disable iff (rst)
        run_div |=> !rsvd_instr_exc)
        else $error("divide raised an exception");

    chk_fixed_latency: assert property (@(posedge ref_clk) disable iff (rst)
        run_div |-> ##1 !wb_valid [*8] ##26 wb_valid)
        else $error("divide did not complete in the fixed cycle count");

    chk_mf_interlock: assert property (@(posedge ref_clk) disable iff (rst)
        mf_req && sreg_pending |-> !mf_ack)
        else $error("special register read was not stalled by pending divide");

    chk_mf_after_write: assert property (@(posedge ref_clk) disable iff (rst)
        sreg_we ##1 mf_req && !mf_sel |-> mf_ack ##1 mf_valid && mf_data == $past(dv.quotient, 2))
        else $error("quotient read after legacy divide returned the wrong value");

    chk_newer_no_sreg: assert property (@(posedge ref_clk) disable iff (rst)
        dv.done && !op_legacy |-> !sreg_we ##1 wb_gpr && wb_dest == $past(op_dest))
        else $error("newer divide touched special registers or lost its destination");

    chk_trunc_identity: assert property (@(posedge ref_clk) disable iff (rst)
        dv.done && chk_b != 32'h0000_0000 |->
            32'(dv.quotient * chk_b + dv.remainder) == chk_a)
        else $error("quotient times divisor plus remainder differs from dividend");

    chk_rem_sign: assert property (@(posedge ref_clk) disable iff (rst)
        dv.done && chk_sgn && chk_b != 32'h0000_0000 && dv.remainder != 32'h0000_0000 |->
            dv.remainder[31] == chk_a[31])
        else $error("signed remainder does not take the dividend sign");

    chk_rem_mag: assert property (@(posedge ref_clk) disable iff (rst)
        dv.done && !chk_sgn && chk_b != 32'h0000_0000 |-> dv.remainder < chk_b)
        else $error("unsigned remainder not below divisor");

    chk_busy_refuse: assert property (@(posedge ref_clk) disable iff (rst)
        run_div |=> !issue_ready [*8])
        else $error("unit accepted a second divide while busy");
endmodule : idu_top

`default_nettype wire

// File: testbench/idu_pipe_model.sv
// integer divide unit bench: writeback side of the core pipeline, a small general register file
// assumes writeback pulses wb_valid for one ref_clk cycle per completed divide
`default_nettype none

module idu_pipe_model (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        wb_valid,
    input  wire logic        wb_gpr,
    input  wire logic [4:0]  wb_dest,
    input  wire logic [31:0] wb_data
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] gpr [32];
    int          legacy_done;

    // only newer-family results land in a general register; legacy ones go to the special pair
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            legacy_done <= 0;
        end else if (wb_valid && wb_gpr) begin
            gpr[wb_dest] <= wb_data;
        end else if (wb_valid) begin
            legacy_done <= legacy_done + 1;
        end
    end
endmodule : idu_pipe_model

`default_nettype wire

// File: testbench/idu_top_tb.sv
// integer divide unit bench: drives decode-side issue and special-register reads, judges writeback
// assumes the fixed 34-cycle divide latency and a one-cycle special-register read answer
`default_nettype none

module idu_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        release6_mode = 1'b0;
    logic        issue_valid = 1'b0;
    logic        issue_ready;
    logic [31:0] issue_instr = 32'h0000_0000;
    logic [31:0] num_val = 32'h0000_0000;
    logic [31:0] den_val = 32'h0000_0000;
    logic        mf_req = 1'b0;
    logic        mf_sel = 1'b0;
    logic        mf_ack;
    logic        mf_valid;
    logic [31:0] mf_data;
    logic        rsvd_instr_exc;
    logic        wb_valid;
    logic        wb_gpr;
    logic [4:0]  wb_dest;
    logic [31:0] wb_data;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    always #2.5 ref_clk = ~ref_clk;

    idu_top idu_top_i (.ref_clk(ref_clk), .rst(rst), .release6_mode(release6_mode),
        .issue_valid(issue_valid), .issue_ready(issue_ready), .issue_instr(issue_instr),
        .num_val(num_val), .den_val(den_val), .mf_req(mf_req), .mf_sel(mf_sel), .mf_ack(mf_ack),
        .mf_valid(mf_valid), .mf_data(mf_data), .rsvd_instr_exc(rsvd_instr_exc),
        .wb_valid(wb_valid), .wb_gpr(wb_gpr), .wb_dest(wb_dest), .wb_data(wb_data));

    idu_pipe_model idu_pipe_model_i (.ref_clk(ref_clk), .rst(rst), .wb_valid(wb_valid),
        .wb_gpr(wb_gpr), .wb_dest(wb_dest), .wb_data(wb_data));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    // covers the run with margin: roughly 20 divides of 35 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    function automatic logic [31:0] ref_div(input logic uns, input logic rem,
                                            input logic [31:0] a, input logic [31:0] b);
        // most-negative by minus one overflows the bench's own arithmetic
        if (!uns && a == 32'h8000_0000 && b == 32'hFFFF_FFFF) begin
            return rem ? 32'h0000_0000 : a;
        end
        if (uns) begin
            return rem ? a % b : a / b;
        end
        return rem ? $signed(a) % $signed(b) : $signed(a) / $signed(b);
    endfunction : ref_div

    // returns just after the edge that takes the word
    task automatic issue(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b);
        int n;
        n = 0;
        @(posedge ref_clk);
        issue_valid <= 1'b1;
        issue_instr <= ins;
        num_val     <= a;
        den_val     <= b;
        #1;
        while (!issue_ready && n < 60) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        @(posedge ref_clk);
        issue_valid <= 1'b0;
    endtask : issue

    // counts cycles from the take edge until wb_valid shows
    task automatic wait_wb(output int lat);
        lat = 1;
        #1;
        while (wb_valid !== 1'b1 && lat < 60) begin
            @(posedge ref_clk);
            #1;
            lat++;
        end
    endtask : wait_wb

    task automatic mf_read(input logic sel, input logic [31:0] exp);
        int n;
        n = 0;
        @(posedge ref_clk);
        mf_req <= 1'b1;
        mf_sel <= sel;
        #1;
        while (!mf_ack && n < 60) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        @(posedge ref_clk);
        mf_req <= 1'b0;
        #1;
        cmp("mf_valid", 32'h1, {31'h0, mf_valid});
        cmp("mf_data", exp, mf_data);
    endtask : mf_read

    function automatic logic [31:0] legacy(input logic [5:0] fn);
        return {6'h00, 5'h01, 5'h02, 10'h000, fn};
    endfunction : legacy

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_newer_family();
        logic [31:0] av [4] = '{32'hFFFF_FFF9, 32'h0000_0007, 32'h8000_0000, 32'h0000_0005};
        logic [31:0] bv [4] = '{32'h0000_0002, 32'hFFFF_FFFE, 32'hFFFF_FFFF, 32'h0000_0000};
        logic [4:0]  dest;
        int          lat;
        for (int p = 0; p < 4; p++) begin
            for (int op = 0; op < 4; op++) begin
                dest = 5'(4 * p + op + 1);
                issue({6'h00, 5'h01, 5'h02, dest, op[0] ? 5'h03 : 5'h02, op[1] ? 6'h1B : 6'h1A},
                      av[p], bv[p]);
                wait_wb(lat);
                cmp("wb latency", 32'(idu_pkg::IDU_LATENCY), 32'(lat));
                cmp("wb_gpr", 32'h1, {31'h0, wb_gpr});
                cmp("wb_dest", {27'h0, dest}, {27'h0, wb_dest});
                @(posedge ref_clk);
                #1;
                if (p < 3) begin
                    cmp("gpr result", ref_div(op[1], op[0], av[p], bv[p]),
                        idu_pipe_model_i.gpr[dest]);
                end
            end
        end
    endtask : t_newer_family

    task automatic t_legacy_stall();
        int n;
        release6_mode <= 1'b0;
        issue(legacy(6'h1A), 32'hFFFF_FFF9, 32'h0000_0002);
        mf_req <= 1'b1;
        mf_sel <= 1'b0;
        n = 1;
        #1;
        while (!mf_ack && n < 60) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        cmp("read stall", 32'(idu_pkg::IDU_LATENCY), 32'(n));
        cmp("legacy wb_valid", 32'h1, {31'h0, wb_valid});
        cmp("legacy wb_gpr", 32'h0, {31'h0, wb_gpr});
        @(posedge ref_clk);
        mf_req <= 1'b0;
        #1;
        cmp("stalled mf_valid", 32'h1, {31'h0, mf_valid});
        cmp("quotient reg", 32'hFFFF_FFFD, mf_data);
        mf_read(1'b1, 32'hFFFF_FFFF);
    endtask : t_legacy_stall

    task automatic t_legacy_edges();
        int lat;
        issue(legacy(6'h1B), 32'hFFFF_FFF9, 32'h0000_0002);
        wait_wb(lat);
        mf_read(1'b0, 32'h7FFF_FFFC);
        mf_read(1'b1, 32'h0000_0001);
        issue(legacy(6'h1A), 32'h0000_1234, 32'h0000_0000);
        wait_wb(lat);
        cmp("zero divisor latency", 32'(idu_pkg::IDU_LATENCY), 32'(lat));
        issue(legacy(6'h1A), 32'h8000_0000, 32'hFFFF_FFFF);
        wait_wb(lat);
        cmp("overflow latency", 32'(idu_pkg::IDU_LATENCY), 32'(lat));
        mf_read(1'b0, 32'h8000_0000);
        mf_read(1'b1, 32'h0000_0000);
        cmp("legacy completions", 32'h0000_0004, 32'(idu_pipe_model_i.legacy_done));
    endtask : t_legacy_edges

    task automatic t_reserved_and_unknown();
        int seen;
        int lat;
        seen = 0;
        release6_mode <= 1'b1;
        issue(legacy(6'h1A), 32'h0000_0009, 32'h0000_0003);
        #1;
        cmp("rsvd_instr_exc", 32'h1, {31'h0, rsvd_instr_exc});
        cmp("ready after reserved", 32'h1, {31'h0, issue_ready});
        issue({6'h00, 5'h01, 5'h02, 5'h03, 5'h02, 6'h20}, 32'h0000_0009, 32'h0000_0003);
        #1;
        cmp("ready after unknown", 32'h1, {31'h0, issue_ready});
        cmp("no second exc", 32'h0, {31'h0, rsvd_instr_exc});
        repeat (40) begin
            @(posedge ref_clk);
            #1;
            seen += int'(wb_valid === 1'b1);
        end
        cmp("no writeback", 32'h0, 32'(seen));
        issue({6'h00, 5'h01, 5'h02, 5'h07, 5'h02, 6'h1A}, 32'h0000_0009, 32'h0000_0003);
        wait_wb(lat);
        cmp("newer mode latency", 32'(idu_pkg::IDU_LATENCY), 32'(lat));
        cmp("newer mode wb_gpr", 32'h1, {31'h0, wb_gpr});
        cmp("newer mode wb_data", 32'h0000_0003, wb_data);
        mf_read(1'b0, 32'h8000_0000);
    endtask : t_reserved_and_unknown

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        cmp("ready after reset", 32'h1, {31'h0, issue_ready});
        mf_read(1'b0, idu_pkg::IDU_SREG_RESET);
        t_newer_family();
        t_legacy_stall();
        t_legacy_edges();
        t_reserved_and_unknown();
        report_and_stop();
    end
endmodule : idu_top_tb

`default_nettype wire
